// File: src/ipfm_top.sv
// in-position, position-fault, pulse-inhibit and idle-current supervision
`timescale 1ns/1ps
module ipfm_top #(
  parameter int ERR_W       = 18,
  parameter bit SLOW_LOOP   = 1'b0,
  parameter bit IDLE_FULL   = 1'b0,
  parameter int TICK_CYCLES = ((SLOW_LOOP ? ipfm_pkg::TICK_US_SLOW : ipfm_pkg::TICK_US)
                               * ipfm_pkg::NS_PER_US) / ipfm_pkg::CLK_PERIOD_NS
) (
  input  wire logic             ref_clk,           // 250 MHz clock
  input  wire logic             sys_rst,           // async reset, active high
  input  wire logic [3:0]       reg_addr,          // register address
  input  wire logic [15:0]      reg_wdata,         // write data
  input  wire logic             reg_wr,            // write strobe
  input  wire logic             reg_rd,            // read strobe
  output logic      [15:0]      reg_rdata,         // read data, cycle after strobe
  input  wire logic [ERR_W-1:0] pos_err,           // signed commanded minus actual
  input  wire logic             step_in,           // step pulse from pulse source
  input  wire logic             inhibit_input_pin, // 1 = contact closed
  output logic                  step_out,          // step pulse to motor stage
  output logic                  in_position,       // motion complete
  output logic                  position_fault,    // servo position fault
  output logic                  idle_active,       // phase current at idle level
  output logic      [6:0]       phase_current_pct, // current level in percent
  output logic      [6:0]       stall_torque_pct,  // active stall prevention torque
  output logic                  irq                // level interrupt
);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [6:0]  IDLE_MAX  = IDLE_FULL ? ipfm_pkg::PCT_MAX : ipfm_pkg::IDLE_MAX_STD;

  // settings and interrupt state
  logic [1:0]          ctrl_q, ctrl_d;
  logic [14:0]         win_q, win_d, dwell_q, dwell_d, flt_q, flt_d;
  logic [1:0]          inh_q, inh_d;
  logic [15:0]         idly_q, idly_d;
  logic [6:0]          idle_pct_q, idle_pct_d, stall_sh_q, stall_sh_d;
  logic [ipfm_pkg::EV_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
  logic [15:0]         rdata_q, rdata_d;
  logic                nv_we_q, nv_we_d, save_pend_q, save_pend_d;
  logic [1:0]          nv_wa_q, nv_wa_d;
  logic [6:0]          nv_wd_q, nv_wd_d, nv_rd;
  // supervision state
  logic [31:0]         div_q, div_d;
  logic                tick_q, tick_d;
  logic [14:0]         dcnt_q, dcnt_d;
  logic                inpos_q, inpos_d, flt_st_q, flt_st_d, idle_q, idle_d;
  logic [15:0]         icnt_q, icnt_d;
  logic                step_q, step_d, irq_q, irq_d;
  logic [6:0]          pct_q, pct_d;
  // power-up load state
  ipfm_pkg::ipfm_load_e ld_q, ld_d;
  logic [6:0]          stall_q, stall_d;

  logic [ERR_W-1:0]    err_mag;
  logic                in_win, at_fault, blocked;
  logic [3:0]          status;

  assign err_mag = pos_err[ERR_W-1] ? ERR_W'(-pos_err) : pos_err;
  assign in_win  = err_mag <= ERR_W'(win_q);
  assign at_fault = ctrl_q[ipfm_pkg::CTRL_SERVO] && err_mag >= ERR_W'(flt_q);
  always_comb begin
    blocked = 1'b0;
    if (ctrl_q[ipfm_pkg::CTRL_PULSE]) begin
      if (inh_q == ipfm_pkg::INH_CLOSED) begin
        blocked = inhibit_input_pin;
      end else if (inh_q == ipfm_pkg::INH_OPEN) begin
        blocked = !inhibit_input_pin;
      end
    end
  end
  assign status = {blocked, idle_q, flt_st_q, inpos_q};

  // register file
  always_comb begin
    ctrl_d      = ctrl_q;
    win_d       = win_q;
    dwell_d     = dwell_q;
    flt_d       = flt_q;
    inh_d       = inh_q;
    idly_d      = idly_q;
    idle_pct_d  = idle_pct_q;
    stall_sh_d  = stall_sh_q;
    ien_d       = ien_q;
    nv_we_d     = 1'b0;
    nv_wa_d     = nv_wa_q;
    nv_wd_d     = nv_wd_q;
    save_pend_d = 1'b0;
    rdata_d     = 16'h0000;
    ev = {idle_d & ~idle_q, flt_st_d & ~flt_st_q, inpos_d & ~inpos_q};
    ist_d = ist_q;
    if (reg_wr && reg_addr == ipfm_pkg::A_IRQCLR) begin
      ist_d = ist_q & ~reg_wdata[ipfm_pkg::EV_W-1:0];
    end
    // set after clear so an event in the clearing cycle survives
    ist_d = ist_d | ev;
    if (save_pend_q) begin
      nv_we_d = 1'b1;
      nv_wa_d = ipfm_pkg::NV_IDLE;
      nv_wd_d = idle_pct_q;
    end
    if (reg_wr) begin
      if (reg_addr == ipfm_pkg::A_CTRL) begin
        ctrl_d = reg_wdata[1:0];
      end else if (reg_addr == ipfm_pkg::A_WINDOW) begin
        win_d = reg_wdata[14:0];
      end else if (reg_addr == ipfm_pkg::A_DWELL) begin
        if (reg_wdata[14:0] <= ipfm_pkg::DWELL_MAX && !reg_wdata[15]) begin
          dwell_d = reg_wdata[14:0];
        end
      end else if (reg_addr == ipfm_pkg::A_FLTLIM) begin
        if (reg_wdata[14:0] >= ipfm_pkg::FLT_MIN && !reg_wdata[15]) begin
          flt_d = reg_wdata[14:0];
        end
      end else if (reg_addr == ipfm_pkg::A_INHSEL) begin
        if (reg_wdata[15:2] == 14'h0000 && reg_wdata[1:0] != 2'h0) begin
          inh_d = reg_wdata[1:0];
        end
      end else if (reg_addr == ipfm_pkg::A_IDLEDLY) begin
        idly_d = reg_wdata;
      end else if (reg_addr == ipfm_pkg::A_IDLECUR) begin
        if (reg_wdata[15:7] == 9'h000 && reg_wdata[6:0] <= IDLE_MAX) begin
          idle_pct_d = reg_wdata[6:0];
        end
      end else if (reg_addr == ipfm_pkg::A_PUIDLE) begin
        if (reg_wdata[15:7] == 9'h000 && reg_wdata[6:0] <= IDLE_MAX) begin
          idle_pct_d = reg_wdata[6:0];
          nv_we_d    = 1'b1;
          nv_wa_d    = ipfm_pkg::NV_IDLE;
          nv_wd_d    = reg_wdata[6:0];
        end
      end else if (reg_addr == ipfm_pkg::A_STALL) begin
        if (reg_wdata[15:7] == 9'h000 && reg_wdata[6:0] <= ipfm_pkg::PCT_MAX) begin
          stall_sh_d = reg_wdata[6:0];
        end
      end else if (reg_addr == ipfm_pkg::A_SAVE) begin
        // stall torque first, idle current on the following cycle
        nv_we_d     = 1'b1;
        nv_wa_d     = ipfm_pkg::NV_STALL;
        nv_wd_d     = stall_sh_q;
        save_pend_d = 1'b1;
      end else if (reg_addr == ipfm_pkg::A_IRQEN) begin
        ien_d = reg_wdata[ipfm_pkg::EV_W-1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == ipfm_pkg::A_CTRL) begin
        rdata_d = {14'h0000, ctrl_q};
      end else if (reg_addr == ipfm_pkg::A_WINDOW) begin
        rdata_d = {1'b0, win_q};
      end else if (reg_addr == ipfm_pkg::A_DWELL) begin
        rdata_d = {1'b0, dwell_q};
      end else if (reg_addr == ipfm_pkg::A_FLTLIM) begin
        rdata_d = {1'b0, flt_q};
      end else if (reg_addr == ipfm_pkg::A_INHSEL) begin
        rdata_d = {14'h0000, inh_q};
      end else if (reg_addr == ipfm_pkg::A_IDLEDLY) begin
        rdata_d = idly_q;
      end else if (reg_addr == ipfm_pkg::A_IDLECUR || reg_addr == ipfm_pkg::A_PUIDLE) begin
        rdata_d = {9'h000, idle_pct_q};
      end else if (reg_addr == ipfm_pkg::A_STALL) begin
        rdata_d = {9'h000, stall_q};
      end else if (reg_addr == ipfm_pkg::A_STATUS) begin
        rdata_d = {12'h000, status};
      end else if (reg_addr == ipfm_pkg::A_IRQST) begin
        rdata_d = {13'h0000, ist_q};
      end else if (reg_addr == ipfm_pkg::A_IRQEN) begin
        rdata_d = {13'h0000, ien_q};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q      <= 2'h0;
      win_q       <= 15'h0000;
      dwell_q     <= ipfm_pkg::DWELL_RST;
      flt_q       <= ipfm_pkg::FLT_RST;
      inh_q       <= ipfm_pkg::INH_GPIO;
      idly_q      <= ipfm_pkg::IDLE_DLY_RST;
      idle_pct_q  <= ipfm_pkg::IDLE_RST;
      stall_sh_q  <= 7'h00;
      ist_q       <= 3'h0;
      ien_q       <= 3'h0;
      nv_we_q     <= 1'b0;
      nv_wa_q     <= 2'h0;
      nv_wd_q     <= 7'h00;
      save_pend_q <= 1'b0;
      rdata_q     <= 16'h0000;
    end else begin
      ctrl_q      <= ctrl_d;
      win_q       <= win_d;
      dwell_q     <= dwell_d;
      flt_q       <= flt_d;
      inh_q       <= inh_d;
      idly_q      <= idly_d;
      idle_pct_q  <= idle_pct_d;
      stall_sh_q  <= stall_sh_d;
      ist_q       <= ist_d;
      ien_q       <= ien_d;
      nv_we_q     <= nv_we_d;
      nv_wa_q     <= nv_wa_d;
      nv_wd_q     <= nv_wd_d;
      save_pend_q <= save_pend_d;
      rdata_q     <= rdata_d;
    end
  end

  // supervision: tick, dwell, fault, step gate, idle timer
  always_comb begin
    tick_d  = 1'b0;
    div_d   = div_q + 32'h0000_0001;
    if (div_q >= TICK_LAST) begin
      div_d  = 32'h0000_0000;
      tick_d = 1'b1;
    end
    dcnt_d  = dcnt_q;
    inpos_d = inpos_q;
    if (!in_win) begin
      dcnt_d  = 15'h0000;
      inpos_d = 1'b0;
    end else if (tick_q) begin
      if (dcnt_q >= dwell_q) begin
        inpos_d = 1'b1;
      end
      if (dcnt_q != ipfm_pkg::WIN_MAX) begin
        dcnt_d = dcnt_q + 15'h0001;
      end
    end
    flt_st_d = at_fault;
    step_d   = step_in && !blocked;
    icnt_d   = icnt_q;
    idle_d   = idle_q;
    if (step_in && !blocked) begin
      icnt_d = 16'h0000;
      idle_d = 1'b0;
    end else if (tick_q && !idle_q) begin
      if (icnt_q >= idly_q) begin
        idle_d = 1'b1;
      end else begin
        icnt_d = icnt_q + 16'h0001;
      end
    end
    pct_d = idle_d ? idle_pct_d : ipfm_pkg::PCT_MAX;
    irq_d = |(ist_d & ien_d);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q    <= 32'h0000_0000;
      tick_q   <= 1'b0;
      dcnt_q   <= 15'h0000;
      inpos_q  <= 1'b0;
      flt_st_q <= 1'b0;
      step_q   <= 1'b0;
      icnt_q   <= 16'h0000;
      idle_q   <= 1'b0;
      pct_q    <= ipfm_pkg::PCT_MAX;
      irq_q    <= 1'b0;
    end else begin
      div_q    <= div_d;
      tick_q   <= tick_d;
      dcnt_q   <= dcnt_d;
      inpos_q  <= inpos_d;
      flt_st_q <= flt_st_d;
      step_q   <= step_d;
      icnt_q   <= icnt_d;
      idle_q   <= idle_d;
      pct_q    <= pct_d;
      irq_q    <= irq_d;
    end
  end

  // stall torque is taken from the store only after reset, i.e. a power cycle
  always_comb begin
    ld_d    = ld_q;
    stall_d = stall_q;
    case (ld_q)
      ipfm_pkg::LD_REQ:  ld_d = ipfm_pkg::LD_WAIT;
      ipfm_pkg::LD_WAIT: begin
        ld_d    = ipfm_pkg::LD_RUN;
        stall_d = nv_rd;
      end
      default:           ld_d = ipfm_pkg::LD_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ld_q    <= ipfm_pkg::LD_REQ;
      stall_q <= 7'h00;
    end else begin
      ld_q    <= ld_d;
      stall_q <= stall_d;
    end
  end

  ipfm_nvmem #(.AW(2), .DW(7)) u_nv (
    .ref_clk (ref_clk),
    .we      (nv_we_q),
    .waddr   (nv_wa_q),
    .wdata   (nv_wd_q),
    .raddr   (ipfm_pkg::NV_STALL),
    .rdata   (nv_rd)
  );

  assign reg_rdata         = rdata_q;
  assign step_out          = step_q;
  assign in_position       = inpos_q;
  assign position_fault    = flt_st_q;
  assign idle_active       = idle_q;
  assign phase_current_pct = pct_q;
  assign stall_torque_pct  = stall_q;
  assign irq               = irq_q;

  inpos_dwell_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(inpos_q) |-> $past(dcnt_q) >= $past(dwell_q) && $past(tick_q))
    else $error("in position without full dwell");
  win_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inpos_q |-> $past(in_win))
    else $error("in position outside window");
  tick_period_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick_q |-> div_q == 32'h0000_0000 && $past(div_q) == TICK_LAST)
    else $error("tick period wrong");
  dwell_limit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dwell_q <= ipfm_pkg::DWELL_MAX)
    else $error("dwell above limit");
  fault_raise_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_fault |=> position_fault)
    else $error("fault not raised");
  stall_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ld_q == ipfm_pkg::LD_RUN |=> $stable(stall_q))
    else $error("stall torque changed without power cycle");
  inhibit_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    step_out |-> $past(step_in) && !$past(blocked))
    else $error("step passed while inhibited");
  idle_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(idle_q) |-> $past(icnt_q) >= $past(idly_q) && $past(tick_q))
    else $error("idle entered early");
  idle_limit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    idle_pct_q <= IDLE_MAX)
    else $error("idle current above limit");
  pu_commit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_wr && reg_addr == ipfm_pkg::A_PUIDLE && reg_wdata <= 16'(IDLE_MAX)
    |=> nv_we_q && nv_wd_q == idle_pct_q && nv_wa_q == ipfm_pkg::NV_IDLE)
    else $error("power-up idle not stored");
  dwell_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !in_win |=> dcnt_q == 15'h0000 && !inpos_q)
    else $error("dwell counter not cleared");
  inpos_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(inpos_q));
  fault_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(flt_st_q));
  idle_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(idle_q));
  block_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) step_in && blocked);
endmodule

// File: inc/ipfm_pkg.sv
// constants, register map and types of the in-position / fault monitor
package ipfm_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          NS_PER_US     = 1000;
  localparam int          TICK_US       = 200;
  localparam int          TICK_US_SLOW  = 250;
  localparam logic [14:0] WIN_MAX       = 15'h7fff;
  localparam logic [14:0] DWELL_MAX     = 15'h7530;
  localparam logic [14:0] DWELL_RST     = 15'h000a;
  localparam logic [14:0] FLT_MIN       = 15'h0001;
  localparam logic [14:0] FLT_RST       = 15'h7fff;
  localparam logic [1:0]  INH_CLOSED    = 2'h1;
  localparam logic [1:0]  INH_OPEN      = 2'h2;
  localparam logic [1:0]  INH_GPIO      = 2'h3;
  localparam logic [6:0]  PCT_MAX       = 7'h64;
  localparam logic [6:0]  IDLE_MAX_STD  = 7'h5a;
  localparam logic [6:0]  IDLE_RST      = 7'h32;
  localparam logic [15:0] IDLE_DLY_RST  = 16'h0005;
  // register offsets
  localparam logic [3:0]  A_CTRL    = 4'h0;
  localparam logic [3:0]  A_WINDOW  = 4'h1;
  localparam logic [3:0]  A_DWELL   = 4'h2;
  localparam logic [3:0]  A_FLTLIM  = 4'h3;
  localparam logic [3:0]  A_INHSEL  = 4'h4;
  localparam logic [3:0]  A_IDLEDLY = 4'h5;
  localparam logic [3:0]  A_IDLECUR = 4'h6;
  localparam logic [3:0]  A_PUIDLE  = 4'h7;
  localparam logic [3:0]  A_STALL   = 4'h8;
  localparam logic [3:0]  A_SAVE    = 4'h9;
  localparam logic [3:0]  A_STATUS  = 4'ha;
  localparam logic [3:0]  A_IRQST   = 4'hb;
  localparam logic [3:0]  A_IRQCLR  = 4'hc;
  localparam logic [3:0]  A_IRQEN   = 4'hd;
  // field positions
  localparam int          CTRL_SERVO = 0;
  localparam int          CTRL_PULSE = 1;
  localparam int          ST_INPOS   = 0;
  localparam int          ST_FAULT   = 1;
  localparam int          ST_IDLE    = 2;
  localparam int          ST_INHIB   = 3;
  localparam int          EV_W       = 3;
  localparam int          EV_INPOS   = 0;
  localparam int          EV_FAULT   = 1;
  localparam int          EV_IDLE    = 2;
  localparam logic [1:0]  NV_IDLE    = 2'h0;
  localparam logic [1:0]  NV_STALL   = 2'h1;
  typedef enum logic [1:0] {
    LD_REQ  = 2'b00,
    LD_WAIT = 2'b01,
    LD_RUN  = 2'b10
  } ipfm_load_e;
endpackage

// File: src/ipfm_nvmem.sv
// small settings store standing in for the non-volatile memory
`timescale 1ns/1ps
module ipfm_nvmem #(
  parameter int AW = 2,
  parameter int DW = 8
) (
  input  wire logic          ref_clk, // clock
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] waddr,   // write address
  input  wire logic [DW-1:0] wdata,   // write data
  input  wire logic [AW-1:0] raddr,   // read address
  output logic      [DW-1:0] rdata    // registered read data
);
  // no reset on purpose: contents must survive sys_rst, which models a power cycle
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: testbench/ipfm_motor_model.sv
// motor with encoder feedback and step pulse source facing the supervision block
`timescale 1ns/1ps
module ipfm_motor_model #(
  parameter int ERR_W = 18
) (
  input  wire logic             ref_clk,  // clock
  input  wire logic [ERR_W-1:0] err_cmd,  // following error the encoder should show
  input  wire logic [7:0]       n_steps,  // length of the next step burst
  input  wire logic             go,       // start a burst, one cycle
  input  wire logic             step_out, // step pulse from the block
  output logic      [ERR_W-1:0] pos_err,  // encoder following error
  output logic                  step_in,  // step pulse to the block
  output int                    moved     // steps the motor really took
);
  // step_in and pos_err settle on the first edge, well inside the opening reset
  logic [7:0] left = 8'h00;
  // one idle cycle between pulses, so every pulse is a separate step
  always @(posedge ref_clk) begin
    pos_err <= err_cmd;
    if (go)
      left <= n_steps;
    else if (left != 8'h00 && !step_in)
      left <= left - 8'h01;
    step_in <= !go && left != 8'h00 && !step_in;
    if (step_out)
      moved <= moved + 1;
  end
endmodule

// File: testbench/tb_top.sv
// self-checking bench of the in-position and fault supervision block
`timescale 1ns/1ps
module tb_top;
  localparam int T = 8;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [17:0] pos_err, err_cmd = 18'h00000;
  logic        step_in, step_out, in_position, position_fault, idle_active, irq;
  logic        pin = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  n_steps = 8'h04;
  logic [6:0]  phase_current_pct, stall_torque_pct;
  logic [15:0] e, m;
  logic        rd_p = 1'b0;
  logic [15:0] exp_q[$], msk_q[$];
  int          moved, n, m0, seed = 68160;
  int          err_total = 0;
  int          checked = 0;
  int          m0_vals[5] = '{99, 100, -100, -99, 32767};

  always #2 ref_clk = ~ref_clk;

  ipfm_top #(.TICK_CYCLES(T)) u_ipfm_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_err(pos_err),
    .step_in(step_in), .inhibit_input_pin(pin), .step_out(step_out),
    .in_position(in_position), .position_fault(position_fault), .idle_active(idle_active),
    .phase_current_pct(phase_current_pct), .stall_torque_pct(stall_torque_pct), .irq(irq));

  ipfm_motor_model #(.ERR_W(18)) u_ipfm_motor_model (
    .ref_clk(ref_clk), .err_cmd(err_cmd), .n_steps(n_steps), .go(go),
    .step_out(step_out), .pos_err(pos_err), .step_in(step_in), .moved(moved));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) rd_p <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_p) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk("reg_rdata", e & m, reg_rdata & m);
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] msk);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wrchk(input logic [3:0] a, input logic [15:0] d, input logic [3:0] ra,
                       input logic [15:0] exp);
    wr(a, d);
    rd(ra, exp, 16'hffff);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic set_err(input int v);
    @(posedge ref_clk);
    err_cmd <= 18'(v);
    repeat (3) @(posedge ref_clk);
  endtask

  // cycles until in_position (sel 0) or idle_active (sel 1) goes high, bounded
  task automatic wait_hi(input int sel, input int lo, input int hi);
    n = 0;
    while ((sel ? idle_active : in_position) !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk(sel ? "idle_cycles" : "inpos_cycles", 16'h1, {15'h0, n >= lo && n <= hi});
  endtask

  task automatic burst();
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic final_report();
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    do_reset();
    // stall torque only takes effect through save and a power cycle
    wr(ipfm_pkg::A_STALL, 16'h003c);
    wr(ipfm_pkg::A_STALL, 16'h0065);
    wr(ipfm_pkg::A_SAVE, 16'h0001);
    wr(ipfm_pkg::A_STALL, 16'h001e);
    do_reset();
    // the stored value reaches the output on the second edge after release
    @(posedge ref_clk);
    chk("stall_torque_pct", 16'h003c, {9'h0, stall_torque_pct});
    rd(ipfm_pkg::A_STALL, 16'h003c, 16'hffff);
    rd(ipfm_pkg::A_DWELL, 16'h000a, 16'hffff);
    rd(ipfm_pkg::A_INHSEL, 16'h0003, 16'hffff);
    rd(ipfm_pkg::A_WINDOW, 16'h0000, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    wrchk(ipfm_pkg::A_DWELL, 16'd30001, ipfm_pkg::A_DWELL, 16'h000a);
    wrchk(ipfm_pkg::A_DWELL, 16'd30000, ipfm_pkg::A_DWELL, 16'd30000);
    wrchk(ipfm_pkg::A_WINDOW, 16'h7fff, ipfm_pkg::A_WINDOW, 16'h7fff);
    wrchk(ipfm_pkg::A_INHSEL, 16'h0000, ipfm_pkg::A_INHSEL, 16'h0003);
    wrchk(ipfm_pkg::A_FLTLIM, 16'h0000, ipfm_pkg::A_FLTLIM, 16'h7fff);
    wrchk(ipfm_pkg::A_FLTLIM, 16'h0001, ipfm_pkg::A_FLTLIM, 16'h0001);
    wrchk(ipfm_pkg::A_PUIDLE, 16'd91, ipfm_pkg::A_IDLECUR, 16'd50);
    wrchk(ipfm_pkg::A_PUIDLE, 16'd90, ipfm_pkg::A_IDLECUR, 16'd90);
    // host keeps idle near half of running current for cooling
    wrchk(ipfm_pkg::A_PUIDLE, 16'd45, ipfm_pkg::A_IDLECUR, 16'd45);
    wrchk(ipfm_pkg::A_IDLECUR, 16'd40, ipfm_pkg::A_PUIDLE, 16'd40);
    // idle drop after the last step
    wr(ipfm_pkg::A_IDLEDLY, 16'h0002);
    burst();
    chk("idle_active", 16'h0, {15'h0, idle_active});
    chk("phase_current_pct", 16'h64, {9'h0, phase_current_pct});
    wait_hi(1, 2 * T - 12, 3 * T + 4);
    @(posedge ref_clk);
    chk("phase_current_pct", 16'd40, {9'h0, phase_current_pct});
    // inhibit selector over every code and pin level, then outside pulse mode
    wr(ipfm_pkg::A_CTRL, 16'h0002);
    for (int i = 0; i < 7; i++) begin
      if (i == 6)
        wr(ipfm_pkg::A_CTRL, 16'h0000);
      wr(ipfm_pkg::A_INHSEL, (i == 6) ? 16'h1 : 16'(i / 2 + 1));
      pin <= (i == 6) ? 1'b1 : 1'(i % 2);
      m0 = moved;
      burst();
      chk("moved", (i < 6 && (i / 2 == 0 && i % 2 == 1 || i / 2 == 1 && i % 2 == 0))
          ? 16'h0 : 16'h4, 16'(moved - m0));
    end
    // servo position fault threshold
    wr(ipfm_pkg::A_CTRL, 16'h0001);
    wr(ipfm_pkg::A_FLTLIM, 16'd100);
    foreach (m0_vals[k]) begin
      set_err(m0_vals[k]);
      chk("position_fault", {15'h0, m0_vals[k] >= 100 || m0_vals[k] <= -100},
          {15'h0, position_fault});
    end
    set_err($random(seed) % 99);
    chk("position_fault", 16'h0, {15'h0, position_fault});
    // in-position dwell, exit and re-entry, with the interrupt masked then enabled
    wr(ipfm_pkg::A_IRQEN, 16'h0000);
    wr(ipfm_pkg::A_WINDOW, 16'd5);
    wr(ipfm_pkg::A_DWELL, 16'd3);
    set_err(20);
    repeat (2 * T) @(posedge ref_clk);
    chk("in_position", 16'h0, {15'h0, in_position});
    set_err($random(seed) % 5);
    wait_hi(0, 3 * T - 3, 4 * T + 1);
    chk("irq", 16'h0, {15'h0, irq});
    rd(ipfm_pkg::A_IRQST, 16'h0001, 16'h0001);
    wr(ipfm_pkg::A_IRQEN, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk("irq", 16'h1, {15'h0, irq});
    wr(ipfm_pkg::A_IRQCLR, 16'h0007);
    repeat (2) @(posedge ref_clk);
    chk("irq", 16'h0, {15'h0, irq});
    rd(ipfm_pkg::A_IRQST, 16'h0000, 16'h0001);
    set_err(6);
    chk("in_position", 16'h0, {15'h0, in_position});
    set_err(-($random(seed) & 3));
    wait_hi(0, 3 * T - 3, 4 * T + 1);
    // servo mode, no pulse command: not blocked, idle, no fault, in position
    rd(ipfm_pkg::A_STATUS, 16'h0005, 16'hffff);
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule
